// ==== inc/afe_test_map.svh ====
`ifndef AFE_TEST_MAP_SVH
`define AFE_TEST_MAP_SVH

// Register offsets on the control port.
`define ADDR_TEST_MODE    8'h0d
`define ADDR_BIAS         8'h12
`define ADDR_FORMAT       8'h14
`define ADDR_ADJUST       8'h15
`define ADDR_REFERENCE    8'h18
`define ADDR_USER1_LOW    8'h19
`define ADDR_USER1_HIGH   8'h1a
`define ADDR_USER2_LOW    8'h1b
`define ADDR_USER2_HIGH   8'h1c
`define ADDR_FILTER       8'h2b
`define ADDR_IMPEDANCE    8'h2c

// Reset values.
`define RST_TEST_MODE     8'h00
`define RST_BIAS          8'h09
`define RST_FORMAT        8'h00
`define RST_ADJUST        8'h0f
`define RST_REFERENCE     8'h03
`define RST_USER          8'h00
`define RST_FILTER        8'h00
`define RST_IMPEDANCE     8'h00

// Field positions.
`define BIT_TWOS          0
`define BIT_INVERT        2
`define BIT_OUT_DISABLE   7
`define BIT_REF_EXTERNAL  6
`define BIT_TUNE_START    6
`define BIT_PN_LONG_RST   5
`define BIT_PN_SHORT_RST  4

// Fixed test words.
`define WORD_MID          12'h800
`define WORD_ONES         12'hfff
`define WORD_ZEROS        12'h000
`define WORD_CHECK_A      12'haaa
`define WORD_CHECK_B      12'h555
`define WORD_SYNC         12'h03f
`define WORD_MIXED        12'ha33

// Timing: filter tuning duration and the system clock period.
`define TUNE_TIME_NS      10000
`define CLK_PERIOD_NS     100

`endif

// ==== inc/afe_test_pkg.sv ====
package afe_test_pkg;

	// Output test mode codes.
	typedef enum logic [3:0] {
		MODE_NORMAL, MODE_MID, MODE_FULL_POS, MODE_FULL_NEG,
		MODE_CHECKER, MODE_PN_LONG, MODE_PN_SHORT, MODE_WORD_TOGGLE,
		MODE_USER, MODE_BIT_TOGGLE, MODE_SYNC, MODE_ONE_HIGH, MODE_MIXED
	} test_mode_t;

	// One access on the control port.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// One converter sample.
	typedef struct packed {
		logic        valid;
		logic [11:0] data;
	} sample_t;

endpackage

// ==== rtl/adc_output_test_pattern_config.sv ====
// Notes on behaviour
// - Adjust register bit 7 clear enables the twelve data bits; set disables; reset enables.
// - Reference bit 6 picks internal or external; low bits set level; reset 0x03.
// - Writing filter bit 6 starts tuning; hardware clears it when tuning finishes.
// - User mode first word comes from user pattern one, low and high bytes.
// - User mode second word comes from pattern two, alternating, never reformatted.
// - Format bit 0 selects offset binary or twos complement; bit 2 inverts data.
// - Codes 1, 2, 3 give midscale, plus full and minus full words, formatted.
// - Checkerboard and word toggle alternate fixed words, without formatting.
// - Codes 9 to 12 give fixed unformatted single words.
// - Codes 1 to 12 replace samples with test data; zero and codes 13 to 15 pass samples.
// - Codes 5 and 6 select long and short sequences, each restartable, formatted.

`include "afe_test_map.svh"

// ----------------------------------------------------------------
// Word FIFO
// ----------------------------------------------------------------
module word_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	// Clock, reset and enable.
	input  wire logic             clk_sys_in,
	input  wire logic             rst_n_in,
	input  wire logic             ce_in,
	// Filling side.
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	// Draining side.
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;

	// Push and pop decisions and the next fill level.
	wire         push       = ce_in && in_valid_in && in_ready_out;
	wire         pop        = ce_in && out_valid_out && out_ready_in;
	wire [AW:0]  next_count = count + (AW+1)'(push) - (AW+1)'(pop);

	// Storage is written without reset.
	always_ff @(posedge clk_sys_in) begin
		if (push) mem[wr_ptr] <= in_data_in;
	end

	// Pointers, level and handshake flags.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			wr_ptr        <= '0;
			rd_ptr        <= '0;
			count         <= '0;
			in_ready_out  <= 1'b1;
			out_valid_out <= 1'b0;
		end else if (ce_in) begin
			if (push) wr_ptr <= wr_ptr + 1'b1;
			if (pop) rd_ptr <= rd_ptr + 1'b1;
			count         <= next_count;
			in_ready_out  <= next_count != FULL;
			out_valid_out <= next_count != '0;
		end
	end

	// Head word; valid only while out_valid_out is high.
	assign out_data_out = mem[rd_ptr];
endmodule

// ----------------------------------------------------------------
// Configuration registers and output word generator
// ----------------------------------------------------------------
module adc_output_test_pattern_config #(
	parameter int TUNE_CYCLES = `TUNE_TIME_NS / `CLK_PERIOD_NS,
	parameter int FIFO_DEPTH  = 16
) (
	// Clock, reset and enable.
	input  wire logic                 clk_sys_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 ce_in,
	// Control port.
	input  wire afe_test_pkg::reg_req_t reg_req_in,
	output logic [7:0]                reg_rdata_out,
	// Converter samples.
	input  wire afe_test_pkg::sample_t  sample_in,
	output logic                      sample_ready_out,
	// Parallel data output.
	output logic [11:0]               data_out,
	output logic                      data_valid_out,
	output logic                      data_oe_out,
	input  wire logic                 data_ready_in,
	// Analog controls.
	output logic [1:0]                lna_bias_out,
	output logic                      ref_external_out,
	output logic [1:0]                ref_level_out,
	output logic                      impedance_high_out,
	output logic [1:0]                drive_strength_out,
	output logic [1:0]                slew_select_out,
	output logic                      tune_busy_out
);
	localparam int NREG = 11;
	localparam int CW   = $clog2(TUNE_CYCLES + 1);
	localparam logic [CW-1:0] TUNE_LAST = CW'(TUNE_CYCLES - 1);
	localparam logic [7:0] ADDRS [NREG] = '{`ADDR_TEST_MODE, `ADDR_BIAS, `ADDR_FORMAT,
		`ADDR_ADJUST, `ADDR_REFERENCE, `ADDR_USER1_LOW, `ADDR_USER1_HIGH,
		`ADDR_USER2_LOW, `ADDR_USER2_HIGH, `ADDR_FILTER, `ADDR_IMPEDANCE};
	localparam logic [7:0] RESETS [NREG] = '{`RST_TEST_MODE, `RST_BIAS, `RST_FORMAT,
		`RST_ADJUST, `RST_REFERENCE, `RST_USER, `RST_USER, `RST_USER, `RST_USER,
		`RST_FILTER, `RST_IMPEDANCE};
	localparam int I_MODE = 0, I_BIAS = 1, I_FMT = 2, I_ADJ = 3, I_REF = 4;
	localparam int I_U1L = 5, I_U1H = 6, I_U2L = 7, I_U2H = 8, I_FILT = 9, I_IMP = 10;

	logic [7:0]  regs [NREG];
	logic [NREG-1:0] hit;
	logic [7:0]  rd_terms [NREG];
	logic [CW-1:0] tune_cnt;
	logic        phase;
	logic [22:0] pn_long;
	logic [8:0]  pn_short;
	logic        fifo_in_ready;
	logic        fifo_valid;
	logic [11:0] fifo_word;

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------

	// Filter bit clears itself at the end of the tuning count.
	wire tune_done  = regs[I_FILT][`BIT_TUNE_START] && tune_cnt == TUNE_LAST;
	wire tune_write = reg_req_in.wr && hit[I_FILT] && reg_req_in.wdata[`BIT_TUNE_START];

	// One decoder and one write process per register.
	for (genvar i = 0; i < NREG; i++) begin : g_reg
		assign hit[i]      = reg_req_in.addr == ADDRS[i];
		assign rd_terms[i] = hit[i] ? regs[i] : 8'h00;
		always_ff @(posedge clk_sys_in) begin
			if (!rst_n_in) begin
				regs[i] <= RESETS[i];
			end else if (ce_in) begin
				if (reg_req_in.wr && hit[i]) begin
					regs[i] <= reg_req_in.wdata; // A new start wins over the self clear.
				end else if (i == I_FILT && tune_done) begin
					regs[i] <= regs[i] & ~(8'h01 << `BIT_TUNE_START);
				end
			end
		end
	end

	// Read data: OR of the selected register, zero for unmapped offsets.
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = 8'h00;
		for (int i = 0; i < NREG; i++) next_rdata = next_rdata | rd_terms[i];
	end

	// Tuning counter runs while the start bit is set.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			tune_cnt <= '0;
		end else if (ce_in) begin
			tune_cnt <= (tune_write || tune_done || !regs[I_FILT][`BIT_TUNE_START]) ? '0 : tune_cnt + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Word generation
	// ------------------------------------------------------------

	// Control fields.
	wire [3:0]  mode_code = regs[I_MODE][3:0];
	wire        twos      = regs[I_FMT][`BIT_TWOS];
	wire        invert    = regs[I_FMT][`BIT_INVERT];
	wire [15:0] user_one  = {regs[I_U1H], regs[I_U1L]};
	wire [15:0] user_two  = {regs[I_U2H], regs[I_U2L]};
	wire        push      = ce_in && sample_in.valid && fifo_in_ready;
	wire        mode_write = reg_req_in.wr && hit[I_MODE];

	// Words that pass through format and inversion.
	wire [11:0] raw_word =
		(mode_code == afe_test_pkg::MODE_MID)      ? `WORD_MID :
		(mode_code == afe_test_pkg::MODE_FULL_POS) ? `WORD_ONES :
		(mode_code == afe_test_pkg::MODE_FULL_NEG) ? `WORD_ZEROS :
		(mode_code == afe_test_pkg::MODE_PN_LONG)  ? pn_long[11:0] :
		(mode_code == afe_test_pkg::MODE_PN_SHORT) ? {pn_short, pn_short[8:6]} :
		sample_in.data;
	wire [11:0] twos_word = raw_word ^ {twos, 11'h000};
	wire [11:0] fmt_word  = invert ? ~twos_word : twos_word;

	// Unformatted patterns, or the formatted word otherwise.
	wire [11:0] next_word =
		(mode_code == afe_test_pkg::MODE_CHECKER)     ? (phase ? `WORD_CHECK_B : `WORD_CHECK_A) :
		(mode_code == afe_test_pkg::MODE_WORD_TOGGLE) ? (phase ? `WORD_ZEROS : `WORD_ONES) :
		(mode_code == afe_test_pkg::MODE_USER)        ? (phase ? user_two[11:0] : user_one[11:0]) :
		(mode_code == afe_test_pkg::MODE_BIT_TOGGLE)  ? `WORD_CHECK_A :
		(mode_code == afe_test_pkg::MODE_SYNC)        ? `WORD_SYNC :
		(mode_code == afe_test_pkg::MODE_ONE_HIGH)    ? `WORD_MID :
		(mode_code == afe_test_pkg::MODE_MIXED)       ? `WORD_MIXED :
		fmt_word;

	// Word phase and the two sequence generators advance once per word.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			phase    <= 1'b0;
			pn_long  <= '1;
			pn_short <= '1;
		end else if (ce_in) begin
			if (mode_write) phase <= 1'b0;
			else if (push) phase <= ~phase;
			if (regs[I_MODE][`BIT_PN_LONG_RST]) pn_long <= '1;
			else if (push) pn_long <= {pn_long[21:0], pn_long[22] ^ pn_long[17]};
			if (regs[I_MODE][`BIT_PN_SHORT_RST]) pn_short <= '1;
			else if (push) pn_short <= {pn_short[7:0], pn_short[8] ^ pn_short[4]};
		end
	end

	// Sixteen-word buffer between generator and output pins.
	word_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys_in    (clk_sys_in),
		.rst_n_in      (rst_n_in),
		.ce_in         (ce_in),
		.in_valid_in   (sample_in.valid),
		.in_data_in    (next_word),
		.in_ready_out  (fifo_in_ready),
		.out_valid_out (fifo_valid),
		.out_data_out  (fifo_word),
		.out_ready_in  (!data_valid_out || data_ready_in)
	);

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------

	// Output stage reloads when empty or when the receiver takes the word.
	wire load = !data_valid_out || data_ready_in;
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			data_out         <= 12'h000;
			data_valid_out   <= 1'b0;
			data_oe_out      <= 1'b1;
			reg_rdata_out    <= 8'h00;
			sample_ready_out <= 1'b0;
			tune_busy_out    <= 1'b0;
		end else if (ce_in) begin
			if (load) begin
				data_valid_out <= fifo_valid;
				if (fifo_valid) data_out <= regs[I_ADJ][`BIT_OUT_DISABLE] ? 12'h000 : fifo_word;
			end
			data_oe_out      <= !regs[I_ADJ][`BIT_OUT_DISABLE];
			if (reg_req_in.rd) reg_rdata_out <= next_rdata;
			sample_ready_out <= fifo_in_ready;
			tune_busy_out    <= regs[I_FILT][`BIT_TUNE_START];
		end
	end

	// Analog selections straight from register bits.
	assign lna_bias_out       = regs[I_BIAS][1:0];
	assign ref_external_out   = regs[I_REF][`BIT_REF_EXTERNAL];
	assign ref_level_out      = regs[I_REF][1:0];
	assign impedance_high_out = regs[I_IMP][0];
	assign drive_strength_out = regs[I_ADJ][1:0];
	assign slew_select_out    = regs[I_ADJ][3:2];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------

	// Output enable follows the disable bit.
	out_disable_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		ce_in && regs[I_ADJ][`BIT_OUT_DISABLE] |=> !data_oe_out) else $error("outputs not disabled");

	// Reference and adjust registers come out of reset at their defaults.
	reset_values_a: assert property (@(posedge clk_sys_in)
		!rst_n_in |=> regs[I_REF] == 8'h03 && regs[I_ADJ] == 8'h0f) else $error("bad reset value");

	// Tuning bit drops after the last count unless restarted.
	tune_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		ce_in && tune_done && !tune_write |=> !regs[I_FILT][`BIT_TUNE_START]) else $error("tune bit stuck");

	// A word pushed in phase zero of user mode is pattern one.
	user_first_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		push && mode_code == afe_test_pkg::MODE_USER && !phase |-> next_word == user_one[11:0])
		else $error("user word one wrong");

	// Any write of the mode register restarts the word phase.
	phase_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		ce_in && mode_write |=> !phase) else $error("phase not cleared");

	// User words alternate between the two patterns.
	user_alt_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		push && !mode_write && mode_code == afe_test_pkg::MODE_USER && !phase
		|=> !ce_in || phase) else $error("user phase did not alternate");

	// Normal data gets format and inversion.
	sample_format_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		push && mode_code == 4'h0 |-> next_word == (sample_in.data ^ {twos, 11'h000} ^ {12{invert}}))
		else $error("sample format wrong");

	// Midscale short is formatted.
	midscale_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		push && mode_code == 4'h1 |-> next_word == (12'h800 ^ {twos, 11'h000} ^ {12{invert}}))
		else $error("midscale word wrong");

	// Checkerboard ignores format.
	checker_word_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		push && mode_code == 4'h4 |-> next_word == (phase ? 12'h555 : 12'haaa)) else $error("checker word wrong");

	// Mixed bit frequency is a fixed word.
	mixed_word_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		push && mode_code == 4'hc |-> next_word == 12'ha33) else $error("mixed word wrong");

	// Long generator restarts at its seed.
	pn_restart_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		ce_in && regs[I_MODE][`BIT_PN_LONG_RST] |=> pn_long == 23'h7fffff) else $error("long sequence not reset");
endmodule

// ==== test/word_receiver_model.sv ====
// ----------------------------------------------------------------
// Receiver that captures parallel output words
// ----------------------------------------------------------------
module word_receiver_model (
	// Clock and reset.
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	// Word stream from the block.
	input  wire logic        valid_in,
	input  wire logic [11:0] data_in,
	output logic             ready_out,
	// Stall request and captured word.
	input  wire logic        hold_in,
	output logic             got_out,
	output logic [11:0]      word_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// The receiver stalls whenever the bench asks it to.
	assign ready_out = !hold_in;

	// A word is taken on an edge where valid and ready are both high.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			got_out <= 1'b0;
		end else begin
			got_out  <= valid_in & ready_out;
			word_out <= data_in;
		end
	end
endmodule

// ==== test/adc_output_test_pattern_config_tb.sv ====
module adc_output_test_pattern_config_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// Signals and model state
	// ----------------------------------------------------------------
	logic                   clk_sys_in, rst_n_in, ce, hold, got, dval, doe, rdy, srdy, rext, imp, busy;
	logic [22:0]            pl = '1;
	logic [8:0]             ps = '1;
	afe_test_pkg::reg_req_t req;
	afe_test_pkg::sample_t  smp;
	logic [7:0]             rdata, saved;
	logic [11:0]            dout, word;
	logic [1:0]             bias, rlvl, drv, slew;
	int                     n_errors = 0, total_checks = 0, seed = 86791;
	bit                     ph;
	logic [7:0]             m [256];
	logic [11:0]            q [$];
	logic [7:0]             adr [12] = '{8'h0d, 8'h12, 8'h14, 8'h15, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h2b,
		8'h2c, 8'h33};
	logic [7:0]             fmt [4] = '{8'h00, 8'h01, 8'h04, 8'h05};

	adc_output_test_pattern_config #(.TUNE_CYCLES(4)) adc_output_test_pattern_config_inst (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce), .reg_req_in(req), .reg_rdata_out(rdata),
		.sample_in(smp), .sample_ready_out(srdy), .data_out(dout), .data_valid_out(dval), .data_oe_out(doe),
		.data_ready_in(rdy), .lna_bias_out(bias), .ref_external_out(rext), .ref_level_out(rlvl),
		.impedance_high_out(imp), .drive_strength_out(drv), .slew_select_out(slew), .tune_busy_out(busy));

	word_receiver_model word_receiver_model_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.valid_in(dval), .data_in(dout), .ready_out(rdy), .hold_in(hold), .got_out(got), .word_out(word));

	// The clock runs at 10 MHz.
	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end

	// ----------------------------------------------------------------
	// Checks and bus tasks
	// ----------------------------------------------------------------
	task chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task close_out;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_in);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk_sys_in);
		req = '0;
		if (a != 8'h33) m[a] = d;
		if (a == 8'h0d) begin
			ph = 1'b0;
			if (d[5]) pl = '1;
			if (d[4]) ps = '1;
		end
	endtask

	task rd(input logic [7:0] a);
		@(negedge clk_sys_in);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk_sys_in);
		req = '0;
		chk(rdata, m[a]);
	endtask

	// Expected word for the current mode, phase and format.
	function automatic logic [11:0] exp_word(input logic [11:0] s);
		logic [11:0] w;
		bit          f;
		f = 1'b0;
		case (m[8'h0d][3:0])
			4'h1: begin w = 12'h800; f = 1'b1; end
			4'h2: begin w = 12'hfff; f = 1'b1; end
			4'h3: begin w = 12'h000; f = 1'b1; end
			4'h4: w = ph ? 12'h555 : 12'haaa;
			4'h5: begin w = pl[11:0]; f = 1'b1; end
			4'h6: begin w = {ps, ps[8:6]}; f = 1'b1; end
			4'h7: w = ph ? 12'h000 : 12'hfff;
			4'h8: w = ph ? {m[8'h1c][3:0], m[8'h1b]} : {m[8'h1a][3:0], m[8'h19]};
			4'h9: w = 12'haaa;
			4'ha: w = 12'h03f;
			4'hb: w = 12'h800;
			4'hc: w = 12'ha33;
			default: begin w = s; f = 1'b1; end
		endcase
		if (f && m[8'h14][0]) w[11] = ~w[11];
		if (f && m[8'h14][2]) w = ~w;
		if (m[8'h15][7]) w = 12'h000;
		return w;
	endfunction

	task push(input logic [11:0] d, input bit h, input bit keep);
		@(negedge clk_sys_in);
		smp = '{valid: 1'b1, data: d};
		hold = h;
		if (keep) begin
			q.push_back(exp_word(d));
			ph = ~ph;
			pl = m[8'h0d][5] ? '1 : {pl[21:0], pl[22] ^ pl[17]};
			ps = m[8'h0d][4] ? '1 : {ps[7:0], ps[8] ^ ps[4]};
		end
	endtask

	task drain;
		int n;
		n = 0;
		@(negedge clk_sys_in);
		smp.valid = 1'b0;
		hold = 1'b0;
		while (q.size() != 0 && n < 300) begin
			@(negedge clk_sys_in);
			n++;
		end
		chk(q.size(), 16'h0000);
	endtask

	// Every word the receiver takes is compared with the model.
	always @(negedge clk_sys_in) begin
		if (got === 1'b1) begin
			if (q.size() == 0) chk(word, 16'hffff);
			else chk(word, q.pop_front());
		end
	end

	// The watchdog cuts a hang short well beyond the expected run.
	initial begin
		#(100 * 20000);
		n_errors++;
		close_out;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n_in = 1'b0;
		ce = 1'b1;
		req = '0;
		smp = '0;
		hold = 1'b0;
		foreach (m[i]) m[i] = 8'h00;
		m[8'h12] = 8'h09;
		m[8'h15] = 8'h0f;
		m[8'h18] = 8'h03;
		repeat (4) @(negedge clk_sys_in);
		rst_n_in = 1'b1;
		chk(doe, 1'b1);
		chk({rext, rlvl, bias, imp}, 6'h1a);
		foreach (adr[i]) rd(adr[i]);
		foreach (adr[i]) begin
			if (adr[i] != 8'h0d && adr[i] != 8'h14 && adr[i] != 8'h15 && adr[i] != 8'h2b) begin
				wr(adr[i], 8'($random(seed)));
				rd(adr[i]);
			end
		end
		chk({rext, rlvl, bias, imp}, {m[8'h18][6], m[8'h18][1:0], m[8'h12][1:0], m[8'h2c][0]});
		wr(8'h2b, 8'h40);
		repeat (2) @(negedge clk_sys_in);
		chk(busy, 1'b1);
		repeat (8) @(negedge clk_sys_in);
		m[8'h2b] = 8'h00;
		rd(8'h2b);
		saved = m[8'h2c];
		ce = 1'b0;
		wr(8'h2c, ~saved);
		m[8'h2c] = saved;
		ce = 1'b1;
		rd(8'h2c);
		for (int c = 0; c < 16; c++) begin
			foreach (fmt[f]) begin
				wr(8'h14, fmt[f]);
				wr(8'h0d, 8'(c) | 8'h30);
				wr(8'h0d, 8'(c));
				repeat (3) push(12'($random(seed)), 1'($random(seed)), 1'b1);
				drain;
			end
		end
		wr(8'h15, 8'h86);
		chk({drv, slew}, 4'h9);
		repeat (2) push(12'($random(seed)), 1'b0, 1'b1);
		drain;
		chk(doe, 1'b0);
		wr(8'h15, 8'h0f);
		wr(8'h0d, 8'h00);
		repeat (17) push(12'($random(seed)), 1'b1, 1'b1);
		repeat (3) @(negedge clk_sys_in);
		chk(srdy, 1'b0);
		push(12'h123, 1'b1, 1'b0);
		drain;
		close_out;
	end
endmodule
